// File: inc/rtq_pkg.sv
// Constants for the reload timer with fixed-priority interrupt vectoring
// Operation
// - Counter steps per 12 clocks or pin falling edge
// - Source-select bit picks internal or pin source
// - Counting only while run-enable is set
// - Low and high bytes count as one pair
// - Overflow loads count pair from reload pair
// - Reload never alters the reload registers
// - Overflow sets flag, raises interrupt if enabled
// - Flags behave like classic timer and interrupt flags
// - Control register bit order, external pairs swapped
// - Fixed priority: external A, overflow, external B
// - Vectors 000, 003, 00B, 013
// - Control and enable registers bit addressable
package rtq_pkg;
    // Register offsets
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h8a;
    localparam logic [7:0] OFS_RELOAD_LOW = 8'h8b;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h8c;
    localparam logic [7:0] OFS_RELOAD_HIGH = 8'h8d;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'ha8;
    // Bit-address groups: byte offset with the low three bits dropped
    localparam logic [4:0] BIT_GRP_TIMER_CONTROL = 5'h11;
    localparam logic [4:0] BIT_GRP_INTERRUPT_ENABLE = 5'h15;
    // Timer control field positions
    localparam int POS_PIN_QUALIFY = 7;
    localparam int POS_SOURCE_SELECT = 6;
    localparam int POS_OVERFLOW_FLAG = 5;
    localparam int POS_RUN_ENABLE = 4;
    localparam int POS_EXT_A_EDGE_FLAG = 3;
    localparam int POS_EXT_A_TRIGGER_TYPE = 2;
    localparam int POS_EXT_B_EDGE_FLAG = 1;
    localparam int POS_EXT_B_TRIGGER_TYPE = 0;
    // Interrupt enable field positions
    localparam int POS_GLOBAL_IRQ_ENABLE = 7;
    localparam int POS_EXT_B_IRQ_ENABLE = 2;
    localparam int POS_TIMER_IRQ_ENABLE = 1;
    localparam int POS_EXT_A_IRQ_ENABLE = 0;
    // Reset values
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
    // Vectors
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_EXT_A = 8'h03;
    localparam logic [7:0] VEC_TIMER = 8'h0b;
    localparam logic [7:0] VEC_EXT_B = 8'h13;
    // Internal source divides the clock by twelve
    localparam logic [3:0] PRESCALE_LAST = 4'hb;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage : rtq_pkg

// File: hw/rtq_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels
module rtq_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // Pins idle high, so reset to one to avoid a false falling edge
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // rtq_sync

// File: hw/rtq_timer.sv
// Auto-reload 16-bit timer/counter with control, enables and fixed-priority vectoring
module rtq_timer (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Byte register access
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    // Single-bit register access
    input wire logic [7:0] bit_addr_in,
    input wire logic bit_wr_in,
    input wire logic bit_wdata_in,
    input wire logic bit_rd_in,
    output logic bit_rdata_out,
    // Pins
    input wire logic count_input_pin_in,
    input wire logic ext_irq_pin_a_in,
    input wire logic ext_irq_pin_b_in,
    // Interrupt vectoring
    input wire logic irq_ack_in,
    output logic irq_req_out,
    output logic [7:0] irq_vector_out
);
    typedef struct packed {
        logic [3:0] prescale;
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0] ctrl;
        logic [7:0] irq_en;
        logic t_prev;
        logic a_prev;
        logic b_prev;
        logic [7:0] sfr_rdata;
        logic bit_rdata;
        logic irq_req;
        logic [7:0] irq_vector;
    } rtq_state_s;

    rtq_state_s st_reg;
    rtq_state_s st_next;
    logic [2:0] pins_sync;
    logic t_sync;
    logic a_sync;
    logic b_sync;
    logic tick_int;
    logic t_fall;
    logic run_ok;
    logic count_inc;
    logic wrap;
    logic req_a;
    logic req_t;
    logic req_b;
    logic wr_count;
    logic wr_reload;

    rtq_sync #(.WIDTH(3)) u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .async_in({count_input_pin_in, ext_irq_pin_a_in, ext_irq_pin_b_in}),
        .sync_out(pins_sync)
    );
    assign t_sync = pins_sync[2];
    assign a_sync = pins_sync[1];
    assign b_sync = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // Count enable and source
    assign tick_int = (st_reg.prescale == rtq_pkg::PRESCALE_LAST);
    assign t_fall = st_reg.t_prev & ~t_sync;
    assign run_ok = st_reg.ctrl[rtq_pkg::POS_RUN_ENABLE] &
        (~st_reg.ctrl[rtq_pkg::POS_PIN_QUALIFY] | a_sync);
    assign count_inc = run_ok &
        (st_reg.ctrl[rtq_pkg::POS_SOURCE_SELECT] ? t_fall : tick_int);
    assign wrap = count_inc & (st_reg.count == rtq_pkg::COUNT_MAX);
    assign wr_count = sfr_wr_in & ((sfr_addr_in == rtq_pkg::OFS_COUNT_LOW) |
        (sfr_addr_in == rtq_pkg::OFS_COUNT_HIGH));
    assign wr_reload = sfr_wr_in & ((sfr_addr_in == rtq_pkg::OFS_RELOAD_LOW) |
        (sfr_addr_in == rtq_pkg::OFS_RELOAD_HIGH));

    // Pending requests, each gated by own and global enable
    assign req_a = st_reg.ctrl[rtq_pkg::POS_EXT_A_EDGE_FLAG] &
        st_reg.irq_en[rtq_pkg::POS_EXT_A_IRQ_ENABLE] &
        st_reg.irq_en[rtq_pkg::POS_GLOBAL_IRQ_ENABLE];
    assign req_t = st_reg.ctrl[rtq_pkg::POS_OVERFLOW_FLAG] &
        st_reg.irq_en[rtq_pkg::POS_TIMER_IRQ_ENABLE] &
        st_reg.irq_en[rtq_pkg::POS_GLOBAL_IRQ_ENABLE];
    assign req_b = st_reg.ctrl[rtq_pkg::POS_EXT_B_EDGE_FLAG] &
        st_reg.irq_en[rtq_pkg::POS_EXT_B_IRQ_ENABLE] &
        st_reg.irq_en[rtq_pkg::POS_GLOBAL_IRQ_ENABLE];

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.t_prev = t_sync;
        st_next.a_prev = a_sync;
        st_next.b_prev = b_sync;
        // Prescaler runs free, so the first tick after run-enable can come early
        st_next.prescale = tick_int ? 4'h0 : st_reg.prescale + 4'h1;
        if (count_inc) begin
            st_next.count = wrap ? st_reg.reload : st_reg.count + 16'h0001;
        end
        // Software byte writes win over counting
        if (sfr_wr_in) begin
            case (sfr_addr_in)
                rtq_pkg::OFS_TIMER_CONTROL: st_next.ctrl = sfr_wdata_in;
                rtq_pkg::OFS_COUNT_LOW: st_next.count[7:0] = sfr_wdata_in;
                rtq_pkg::OFS_COUNT_HIGH: st_next.count[15:8] = sfr_wdata_in;
                rtq_pkg::OFS_RELOAD_LOW: st_next.reload[7:0] = sfr_wdata_in;
                rtq_pkg::OFS_RELOAD_HIGH: st_next.reload[15:8] = sfr_wdata_in;
                rtq_pkg::OFS_INTERRUPT_ENABLE: st_next.irq_en = sfr_wdata_in;
                default: st_next.irq_en = st_next.irq_en;
            endcase
        end
        if (bit_wr_in) begin
            if (bit_addr_in[7:3] == rtq_pkg::BIT_GRP_TIMER_CONTROL) begin
                st_next.ctrl[bit_addr_in[2:0]] = bit_wdata_in;
            end else if (bit_addr_in[7:3] == rtq_pkg::BIT_GRP_INTERRUPT_ENABLE) begin
                st_next.irq_en[bit_addr_in[2:0]] = bit_wdata_in;
            end
        end
        // Vectoring clears the served flag, like the classic core
        if (irq_ack_in && st_reg.irq_req) begin
            case (st_reg.irq_vector)
                rtq_pkg::VEC_EXT_A: st_next.ctrl[rtq_pkg::POS_EXT_A_EDGE_FLAG] = 1'b0;
                rtq_pkg::VEC_TIMER: st_next.ctrl[rtq_pkg::POS_OVERFLOW_FLAG] = 1'b0;
                rtq_pkg::VEC_EXT_B: st_next.ctrl[rtq_pkg::POS_EXT_B_EDGE_FLAG] = 1'b0;
                default: st_next.ctrl = st_next.ctrl;
            endcase
        end
        // Hardware sets last so an event in a clear cycle is kept
        if (wrap) begin
            st_next.ctrl[rtq_pkg::POS_OVERFLOW_FLAG] = 1'b1;
        end
        if (st_reg.ctrl[rtq_pkg::POS_EXT_A_TRIGGER_TYPE]) begin
            if (st_reg.a_prev && !a_sync) begin
                st_next.ctrl[rtq_pkg::POS_EXT_A_EDGE_FLAG] = 1'b1;
            end
        end else begin
            st_next.ctrl[rtq_pkg::POS_EXT_A_EDGE_FLAG] = ~a_sync;
        end
        if (st_reg.ctrl[rtq_pkg::POS_EXT_B_TRIGGER_TYPE]) begin
            if (st_reg.b_prev && !b_sync) begin
                st_next.ctrl[rtq_pkg::POS_EXT_B_EDGE_FLAG] = 1'b1;
            end
        end else begin
            st_next.ctrl[rtq_pkg::POS_EXT_B_EDGE_FLAG] = ~b_sync;
        end
        // Read data, unmapped reads return zero
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                rtq_pkg::OFS_TIMER_CONTROL: st_next.sfr_rdata = st_reg.ctrl;
                rtq_pkg::OFS_COUNT_LOW: st_next.sfr_rdata = st_reg.count[7:0];
                rtq_pkg::OFS_COUNT_HIGH: st_next.sfr_rdata = st_reg.count[15:8];
                rtq_pkg::OFS_RELOAD_LOW: st_next.sfr_rdata = st_reg.reload[7:0];
                rtq_pkg::OFS_RELOAD_HIGH: st_next.sfr_rdata = st_reg.reload[15:8];
                rtq_pkg::OFS_INTERRUPT_ENABLE: st_next.sfr_rdata = st_reg.irq_en;
                default: st_next.sfr_rdata = 8'h00;
            endcase
        end
        if (bit_rd_in) begin
            if (bit_addr_in[7:3] == rtq_pkg::BIT_GRP_TIMER_CONTROL) begin
                st_next.bit_rdata = st_reg.ctrl[bit_addr_in[2:0]];
            end else if (bit_addr_in[7:3] == rtq_pkg::BIT_GRP_INTERRUPT_ENABLE) begin
                st_next.bit_rdata = st_reg.irq_en[bit_addr_in[2:0]];
            end else begin
                st_next.bit_rdata = 1'b0;
            end
        end
        // Fixed single-level priority
        st_next.irq_req = req_a | req_t | req_b;
        if (req_a) begin
            st_next.irq_vector = rtq_pkg::VEC_EXT_A;
        end else if (req_t) begin
            st_next.irq_vector = rtq_pkg::VEC_TIMER;
        end else if (req_b) begin
            st_next.irq_vector = rtq_pkg::VEC_EXT_B;
        end else begin
            st_next.irq_vector = rtq_pkg::VEC_RESET;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_reg.prescale <= 4'h0;
            st_reg.count <= {rtq_pkg::RST_BYTE, rtq_pkg::RST_BYTE};
            st_reg.reload <= {rtq_pkg::RST_BYTE, rtq_pkg::RST_BYTE};
            st_reg.ctrl <= rtq_pkg::RST_TIMER_CONTROL;
            st_reg.irq_en <= rtq_pkg::RST_INTERRUPT_ENABLE;
            st_reg.t_prev <= 1'b1;
            st_reg.a_prev <= 1'b1;
            st_reg.b_prev <= 1'b1;
            st_reg.sfr_rdata <= 8'h00;
            st_reg.bit_rdata <= 1'b0;
            st_reg.irq_req <= 1'b0;
            st_reg.irq_vector <= rtq_pkg::VEC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata_out = st_reg.sfr_rdata;
    assign bit_rdata_out = st_reg.bit_rdata;
    assign irq_req_out = st_reg.irq_req;
    assign irq_vector_out = st_reg.irq_vector;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    a_internal_tick_gap: assert property (
        (count_inc && !st_reg.ctrl[rtq_pkg::POS_SOURCE_SELECT] && run_ok) |=>
            !count_inc [*8] ##1 !count_inc [*3])
        else $error("internal source stepped faster than once per twelve");
    a_stopped_holds: assert property (
        (!st_reg.ctrl[rtq_pkg::POS_RUN_ENABLE] && !wr_count) |=> $stable(st_reg.count))
        else $error("count moved while run enable clear");
    a_pair_increment: assert property (
        (count_inc && !wrap && !wr_count) |=> st_reg.count == $past(st_reg.count) + 16'h0001)
        else $error("count pair did not step by one");
    a_wrap_reload: assert property (
        (wrap && !wr_count) |=> st_reg.count == $past(st_reg.reload))
        else $error("overflow did not load reload value");
    a_reload_kept: assert property (
        !wr_reload |=> $stable(st_reg.reload))
        else $error("reload registers changed without a write");
    a_wrap_sets_flag: assert property (
        wrap |=> st_reg.ctrl[rtq_pkg::POS_OVERFLOW_FLAG])
        else $error("overflow flag not set on wrap");
    a_ext_a_first: assert property (
        req_a |=> irq_req_out && irq_vector_out == rtq_pkg::VEC_EXT_A)
        else $error("external A not served first");
    a_timer_over_b: assert property (
        (!req_a && req_t) |=> irq_vector_out == rtq_pkg::VEC_TIMER)
        else $error("overflow vector not chosen over external B");
    a_global_gate: assert property (
        !st_reg.irq_en[rtq_pkg::POS_GLOBAL_IRQ_ENABLE] |=> !irq_req_out)
        else $error("request raised with global enable clear");
    a_qualify_blocks: assert property (
        (st_reg.ctrl[rtq_pkg::POS_PIN_QUALIFY] && !a_sync) |-> !count_inc)
        else $error("counted while qualify pin low");
    a_level_follows: assert property (
        !st_reg.ctrl[rtq_pkg::POS_EXT_B_TRIGGER_TYPE] && !b_sync && !(sfr_wr_in || bit_wr_in)
            |=> st_reg.ctrl[rtq_pkg::POS_EXT_B_EDGE_FLAG])
        else $error("level mode flag did not follow low pin");
endmodule // rtq_timer

// File: bench/tb.sv
// Self-checking bench for the reload timer with fixed-priority vectoring
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic sfr_rd_in = 1'b0;
    logic [7:0] bit_addr_in = 8'h00;
    logic bit_wr_in = 1'b0;
    logic bit_wdata_in = 1'b0;
    logic bit_rd_in = 1'b0;
    logic count_input_pin_in = 1'b1;
    logic ext_irq_pin_a_in = 1'b1;
    logic ext_irq_pin_b_in = 1'b1;
    logic irq_ack_in = 1'b0;
    logic [7:0] sfr_rdata_out;
    logic bit_rdata_out;
    logic irq_req_out;
    logic [7:0] irq_vector_out;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] rdv;
    logic [7:0] held;
    logic [7:0] map [7] = '{8'h88, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha8, 8'h89};

    rtq_timer dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
        .sfr_rdata_out(sfr_rdata_out), .bit_addr_in(bit_addr_in), .bit_wr_in(bit_wr_in),
        .bit_wdata_in(bit_wdata_in), .bit_rd_in(bit_rd_in), .bit_rdata_out(bit_rdata_out),
        .count_input_pin_in(count_input_pin_in), .ext_irq_pin_a_in(ext_irq_pin_a_in),
        .ext_irq_pin_b_in(ext_irq_pin_b_in), .irq_ack_in(irq_ack_in),
        .irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out));

    always #25 clock_in = ~clock_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #5 sfr_wr_in = 1'b1;
        sfr_addr_in = a;
        sfr_wdata_in = d;
        @(posedge clock_in);
        #5 sfr_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock_in);
        #5 sfr_rd_in = 1'b1;
        sfr_addr_in = a;
        @(posedge clock_in);
        #5 sfr_rd_in = 1'b0;
        rdv = sfr_rdata_out;
    endtask

    task automatic bit_op(input logic [7:0] a, input logic w, input logic d);
        @(posedge clock_in);
        #5 bit_addr_in = a;
        bit_wr_in = w;
        bit_rd_in = !w;
        bit_wdata_in = d;
        @(posedge clock_in);
        #5 bit_wr_in = 1'b0;
        bit_rd_in = 1'b0;
        rdv = {7'h00, bit_rdata_out};
    endtask

    task automatic wait_irq();
        // Look off the edge so a request launched there is settled
        for (int i = 0; i < 80 && irq_req_out !== 1'b1; i++) begin
            @(posedge clock_in);
            #5;
        end
        repeat (2) @(posedge clock_in);
        #5;
    endtask

    task automatic ack();
        @(posedge clock_in);
        #5 irq_ack_in = 1'b1;
        @(posedge clock_in);
        #5 irq_ack_in = 1'b0;
        repeat (3) @(posedge clock_in);
        #5;
    endtask

    // Pulse width covers the two-flop pin synchroniser
    task automatic pins(input logic c, input logic a, input logic b, input int n);
        repeat (n) begin
            @(posedge clock_in);
            #5 {count_input_pin_in, ext_irq_pin_a_in, ext_irq_pin_b_in} = {c, a, b};
            repeat (4) @(posedge clock_in);
            #5 {count_input_pin_in, ext_irq_pin_b_in} = 2'b11;
            repeat (4) @(posedge clock_in);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic reset_values();
        foreach (map[i]) begin
            rd(map[i]);
            chk(rdv, 8'h00);
        end
    endtask

    task automatic timer_overflow();
        wr(8'h8b, 8'h34);
        wr(8'h8d, 8'h12);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        wr(8'ha8, 8'h82);
        bit_op(8'haf, 1'b0, 1'b0);
        chk(rdv, 8'h01);
        bit_op(8'h8c, 1'b1, 1'b1);
        wait_irq();
        chk(irq_vector_out, 8'h0b);
        rd(8'h8c);
        chk(rdv, 8'h12);
        rd(8'h8b);
        chk(rdv, 8'h34);
        rd(8'h8d);
        chk(rdv, 8'h12);
        rd(8'h88);
        chk(rdv, 8'h30);
        bit_op(8'h8d, 1'b0, 1'b0);
        chk(rdv, 8'h01);
        ack();
        chk({7'h00, irq_req_out}, 8'h00);
        bit_op(8'h8c, 1'b1, 1'b0);
        rd(8'h8a);
        held = rdv;
        repeat (30) @(posedge clock_in);
        rd(8'h8a);
        chk(rdv, held);
    endtask

    task automatic pin_counting();
        wr(8'ha8, 8'h00);
        wr(8'h8a, 8'h00);
        wr(8'h8c, 8'h00);
        wr(8'h88, 8'h50);
        pins(1'b0, 1'b1, 1'b1, 3);
        rd(8'h8a);
        chk(rdv, 8'h03);
        wr(8'h88, 8'hd0);
        pins(1'b0, 1'b0, 1'b1, 2);
        rd(8'h8a);
        chk(rdv, 8'h03);
        rd(8'h88);
        chk(rdv, 8'hd8);
        pins(1'b0, 1'b1, 1'b1, 1);
        rd(8'h8a);
        chk(rdv, 8'h04);
        // Level mode on external B, enables set by single bits
        bit_op(8'haf, 1'b1, 1'b1);
        bit_op(8'haa, 1'b1, 1'b1);
        rd(8'ha8);
        chk(rdv, 8'h84);
        @(posedge clock_in);
        #5 ext_irq_pin_b_in = 1'b0;
        repeat (5) @(posedge clock_in);
        #5;
        chk(irq_vector_out, 8'h13);
        rd(8'h88);
        chk(rdv, 8'hd2);
        @(posedge clock_in);
        #5 ext_irq_pin_b_in = 1'b1;
        repeat (5) @(posedge clock_in);
        #5;
        chk({7'h00, irq_req_out}, 8'h00);
    endtask

    task automatic priority_order();
        wr(8'h88, 8'h05);
        wr(8'ha8, 8'h05);
        pins(1'b1, 1'b1, 1'b0, 1);
        chk({7'h00, irq_req_out}, 8'h00);
        wr(8'ha8, 8'h85);
        wait_irq();
        chk(irq_vector_out, 8'h13);
        ack();
        pins(1'b1, 1'b0, 1'b0, 1);
        rd(8'h88);
        chk(rdv, 8'h0f);
        chk(irq_vector_out, 8'h03);
        ack();
        chk(irq_vector_out, 8'h13);
        ack();
        chk({7'h00, irq_req_out}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs roughly 250 cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (5) @(posedge clock_in);
        #5 rst_n_in = 1'b1;
        reset_values();
        timer_overflow();
        pin_counting();
        priority_order();
        tally_and_finish();
    end
endmodule // tb
